// ===== logic/ecs_ep0_cfg.sv
`include "ecs_regs.svh"
`default_nettype none
module ecs_ep0_cfg #(
    parameter int AW = 10,
    parameter logic [12:0] FIFO_BYTES = `ECS_FIFO_BYTES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU side of the EP0 buffer
    input wire logic buf_wr_stb,
    input wire logic [1:0] buf_wr_bytes,
    input wire logic [8:0] cont_tx_len,
    // Protocol engine
    input wire logic in_token_stb,
    input wire logic out_pkt_stb,
    input wire logic [10:0] out_pkt_len,
    input wire logic req_stb,
    input wire ecs_pkg::ecs_req_t req,
    input wire ecs_pkg::ecs_dev_state_t dev_state,
    output ecs_pkg::ecs_ans_t ans,
    output logic ans_stb,
    output logic auto_zlp_stb,
    // Buffer placement
    output logic [11:0] rd_buf_base,
    output logic [11:0] wr_buf_base,
    output logic [11:0] act_buf_base,
    output logic [8:0] act_buf_bytes,
    output logic [8:0] rx_fill_bytes,
    // Flags
    output logic buffer_valid_flag,
    output logic stage_change_flag,
    output logic empty_or_oversize_flag,
    output logic device_state_change_flag
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [12:0] blk_base(input logic [5:0] blk);
        blk_base = 13'({blk, 6'h00}) * 13'h0001;
    endfunction

    function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
        min9 = (a < b) ? a : b;
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] mode_ff;
    logic [6:0] ep0_max_packet_bytes_ff;
    logic [1:0] auto_ff;
    logic [1:0] hs_ff;
    logic dir_ff;
    logic [3:0] ien_ff;
    logic stage_ff, ovr_ff, device_state_change_flag_ff, range_ff;
    ecs_pkg::ecs_buf_phase_t phase_ff;
    logic [8:0] cnt_ff;
    ecs_pkg::ecs_dev_state_t prev_state_ff;

    logic read_multi_packet, write_multi_packet;
    logic auto_config_response, auto_address_response;
    logic [5:0] rd_blk, wr_blk;
    logic [8:0] mps9;
    assign read_multi_packet = mode_ff[`ECS_RD_MULTI_BIT];
    assign write_multi_packet = mode_ff[`ECS_WR_MULTI_BIT];
    assign rd_blk = mode_ff[`ECS_RD_BLK_HI:`ECS_RD_BLK_LO];
    assign wr_blk = mode_ff[`ECS_WR_BLK_HI:`ECS_WR_BLK_LO];
    assign auto_config_response = auto_ff[`ECS_AUTO_CFG_BIT];
    assign auto_address_response = auto_ff[`ECS_AUTO_ADR_BIT];
    assign mps9 = {2'b00, ep0_max_packet_bytes_ff};

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    logic aw_held_ff, w_held_ff;
    logic [AW-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_go;
    logic [15:0] wmask;
    assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wmask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

    // Ready flops hold the inverse of the held flags so the ports stay registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_ff <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_ff <= 1'b0;
                s_axi_wready <= 1'b1;
            end
        end
    end

    logic wr_mode, wr_mps, wr_auto, wr_ctrl, wr_stat, wr_ien;
    assign wr_mode = wr_go && awaddr_ff == `ECS_ADDR_BUF_MODE;
    assign wr_mps = wr_go && awaddr_ff == `ECS_ADDR_MPS;
    assign wr_auto = wr_go && awaddr_ff == `ECS_ADDR_AUTO;
    assign wr_ctrl = wr_go && awaddr_ff == `ECS_ADDR_CTRL;
    assign wr_stat = wr_go && awaddr_ff == `ECS_ADDR_STAT;
    assign wr_ien = wr_go && awaddr_ff == `ECS_ADDR_IEN;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_mode || wr_mps || wr_auto || wr_ctrl || wr_stat || wr_ien) ? 2'h0 : 2'h3;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff <= `ECS_RST_BUF_MODE;
            ep0_max_packet_bytes_ff <= 7'(`ECS_RST_MPS);
            auto_ff <= 2'h0;
            hs_ff <= `ECS_HS_NAK;
            dir_ff <= 1'b0;
            ien_ff <= 4'h0;
        end else begin
            // Reserved bits 14 and 6 stay zero
            if (wr_mode) begin
                mode_ff <= (mode_ff & ~wmask) | (wdata_ff[15:0] & wmask & 16'hBFBF);
            end
            if (wr_mps && wstrb_ff[0]) begin
                ep0_max_packet_bytes_ff <= wdata_ff[`ECS_MPS_HI:0];
            end
            if (wr_auto && wstrb_ff[0]) begin
                auto_ff <= wdata_ff[1:0];
            end
            if (wr_ctrl && wstrb_ff[1] && phase_ff == ecs_pkg::BP_OPEN) begin
                hs_ff <= wdata_ff[`ECS_HS_HI:`ECS_HS_LO];
            end
            if (wr_ctrl && wstrb_ff[0]) begin
                dir_ff <= wdata_ff[`ECS_DIR_BIT];
            end
            if (wr_ien && wstrb_ff[0]) begin
                ien_ff <= wdata_ff[3:0];
            end
        end
    end

    // ----------------------------------------
    // Buffer placement
    // ----------------------------------------
    logic [12:0] rd_base13, wr_base13, rd_end, wr_end;
    logic [8:0] rd_size, wr_size;
    assign rd_base13 = blk_base(rd_blk);
    assign wr_base13 = blk_base(wr_blk);
    assign rd_size = read_multi_packet ? cont_tx_len : 9'(`ECS_BLOCK_BYTES);
    assign wr_size = write_multi_packet ? `ECS_CONT_RX_BYTES : 9'(`ECS_BLOCK_BYTES);
    assign rd_end = rd_base13 + {4'h0, rd_size};
    assign wr_end = wr_base13 + {4'h0, wr_size};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_buf_base <= 12'h000;
            wr_buf_base <= 12'h000;
            act_buf_base <= 12'h000;
            act_buf_bytes <= 9'h000;
        end else begin
            rd_buf_base <= rd_base13[11:0];
            wr_buf_base <= wr_base13[11:0];
            act_buf_base <= dir_ff ? rd_base13[11:0] : wr_base13[11:0];
            act_buf_bytes <= dir_ff ? rd_size : wr_size;
        end
    end

    // ----------------------------------------
    // Transfer engine
    // ----------------------------------------
    logic cpu_force, cpu_clear, fill_done, rx_short, rx_over;
    logic [8:0] cnt_sum, tx_len, rx_sum;
    assign cpu_force = wr_ctrl && wstrb_ff[1] && wdata_ff[`ECS_VALID_BIT];
    assign cpu_clear = wr_ctrl && wstrb_ff[1] && wdata_ff[`ECS_CLEAR_BIT];
    assign cnt_sum = cnt_ff + {7'h00, buf_wr_bytes};
    // fill completes at max packet or length
    assign fill_done = read_multi_packet ? (cnt_sum >= cont_tx_len) : (cnt_sum >= mps9);
    assign tx_len = min9(cnt_ff, mps9);
    assign rx_over = {2'b00, mps9} < out_pkt_len;
    assign rx_short = out_pkt_len[8:0] < mps9;
    assign rx_sum = cnt_ff + out_pkt_len[8:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_ff <= ecs_pkg::BP_OPEN;
            cnt_ff <= 9'h000;
            ans <= '0;
            ans_stb <= 1'b0;
            ovr_ff <= 1'b0;
        end else begin
            ans_stb <= 1'b0;
            if (wr_stat && wstrb_ff[0] && wdata_ff[`ECS_ST_OVR_BIT]) begin
                ovr_ff <= 1'b0;
            end
            if (cpu_clear) begin
                phase_ff <= ecs_pkg::BP_OPEN;
                cnt_ff <= 9'h000;
            end else if (dir_ff) begin
                if (phase_ff == ecs_pkg::BP_OPEN) begin
                    if (cpu_force) begin
                        phase_ff <= ecs_pkg::BP_VALID;
                    end else if (buf_wr_stb) begin
                        cnt_ff <= cnt_sum;
                        if (fill_done) begin
                            phase_ff <= ecs_pkg::BP_VALID;
                        end
                    end
                end
                if (in_token_stb) begin
                    ans_stb <= 1'b1;
                    ans.len <= 7'h00;
                    if (hs_ff[1]) begin
                        ans.code <= ecs_pkg::RS_STALL;
                    end else if (hs_ff == `ECS_HS_NAK || phase_ff != ecs_pkg::BP_VALID) begin
                        ans.code <= ecs_pkg::RS_NAK;
                    end else begin
                        ans.code <= ecs_pkg::RS_DATA;
                        ans.len <= tx_len[6:0];
                        cnt_ff <= cnt_ff - tx_len;
                        // end after one packet, length or short
                        if (!read_multi_packet || cnt_ff == tx_len || tx_len < mps9) begin
                            phase_ff <= ecs_pkg::BP_OPEN;
                            cnt_ff <= 9'h000;
                        end
                    end
                end
            end else if (out_pkt_stb) begin
                ans_stb <= 1'b1;
                ans.len <= 7'h00;
                if (hs_ff[1]) begin
                    ans.code <= ecs_pkg::RS_STALL;
                end else if (hs_ff == `ECS_HS_NAK || phase_ff != ecs_pkg::BP_OPEN) begin
                    ans.code <= ecs_pkg::RS_NAK;
                end else if (rx_over) begin
                    ans.code <= ecs_pkg::RS_STALL;
                    ovr_ff <= 1'b1;
                end else begin
                    ans.code <= ecs_pkg::RS_ACK;
                    ans.len <= out_pkt_len[6:0];
                    cnt_ff <= rx_sum;
                    // unit, short or 256 bytes completes
                    if (!write_multi_packet || rx_short || rx_sum >= `ECS_CONT_RX_BYTES) begin
                        phase_ff <= ecs_pkg::BP_VALID;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Setup requests and status flags
    // ----------------------------------------
    logic cfg_auto, adr_auto, req_ours, state_moved, stage_set, device_state_change_flag_set, stage_error_irq_enable_set;
    assign cfg_auto = auto_config_response && req.set_config &&
        ((dev_state == ecs_pkg::DS_ADDRESS && req.value_nonzero) ||
         (dev_state == ecs_pkg::DS_CONFIGURED && !req.value_nonzero));
    assign adr_auto = auto_address_response && req.set_address && dev_state == ecs_pkg::DS_DEFAULT;
    assign req_ours = req.set_config || req.set_address;
    assign stage_error_irq_enable_set = out_pkt_stb && !dir_ff && !hs_ff[1] && hs_ff != `ECS_HS_NAK &&
        phase_ff == ecs_pkg::BP_OPEN && rx_over && ien_ff[`ECS_IEN_STAGE_ERROR_IRQ_ENABLE_BIT];
    // no auto answer sets stage flag
    assign stage_set = (req_stb && req_ours && !cfg_auto && !adr_auto) || stage_error_irq_enable_set;
    assign state_moved = prev_state_ff != dev_state;
    assign device_state_change_flag_set = state_moved &&
        ((ien_ff[`ECS_IEN_ADDRESS_CHANGE_IRQ_ENABLE_BIT] && (prev_state_ff == ecs_pkg::DS_DEFAULT ||
          dev_state == ecs_pkg::DS_DEFAULT)) ||
         (ien_ff[`ECS_IEN_CONFIG_CHANGE_IRQ_ENABLE_BIT] && (prev_state_ff == ecs_pkg::DS_CONFIGURED ||
          dev_state == ecs_pkg::DS_CONFIGURED)));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_ff <= 1'b0;
            device_state_change_flag_ff <= 1'b0;
            range_ff <= 1'b0;
            auto_zlp_stb <= 1'b0;
            prev_state_ff <= ecs_pkg::DS_DEFAULT;
        end else begin
            prev_state_ff <= dev_state;
            auto_zlp_stb <= req_stb && (cfg_auto || adr_auto);
            // Set wins over a same-cycle clear
            stage_ff <= (stage_ff && !(wr_stat && wstrb_ff[0] && wdata_ff[`ECS_ST_STAGE_BIT])) || stage_set;
            device_state_change_flag_ff <= (device_state_change_flag_ff && !(wr_stat && wstrb_ff[0] && wdata_ff[`ECS_ST_DEVICE_STATE_CHANGE_FLAG_BIT])) || device_state_change_flag_set;
            range_ff <= rd_blk > `ECS_LAST_BLOCK || wr_blk > `ECS_LAST_BLOCK ||
                rd_end > FIFO_BYTES || wr_end > FIFO_BYTES;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buffer_valid_flag <= 1'b0;
            stage_change_flag <= 1'b0;
            empty_or_oversize_flag <= 1'b0;
            device_state_change_flag <= 1'b0;
            rx_fill_bytes <= 9'h000;
        end else begin
            buffer_valid_flag <= phase_ff == ecs_pkg::BP_VALID;
            stage_change_flag <= stage_ff;
            empty_or_oversize_flag <= ovr_ff;
            device_state_change_flag <= device_state_change_flag_ff;
            rx_fill_bytes <= cnt_ff;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    logic [15:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_word = 16'h0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `ECS_ADDR_BUF_MODE: rd_word = mode_ff;
            `ECS_ADDR_MPS: rd_word = {9'h000, ep0_max_packet_bytes_ff};
            `ECS_ADDR_AUTO: rd_word = {14'h0000, auto_ff};
            `ECS_ADDR_CTRL: rd_word = {hs_ff, phase_ff == ecs_pkg::BP_VALID, 12'h000, dir_ff};
            `ECS_ADDR_STAT: rd_word = {12'h000, range_ff, device_state_change_flag_ff, ovr_ff, stage_ff};
            `ECS_ADDR_IEN: rd_word = {12'h000, ien_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_word};
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h3;
        end else if (s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== logic/ecs_regs.svh
`ifndef ECS_REGS_SVH
`define ECS_REGS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define ECS_IDX_BUF_MODE 8'h28
`define ECS_IDX_MPS 8'h2A
`define ECS_IDX_AUTO 8'h2C
`define ECS_IDX_CTRL 8'h40
`define ECS_IDX_STAT 8'h41
`define ECS_IDX_IEN 8'h42
`define ECS_ADDR_BUF_MODE 10'h0A0
`define ECS_ADDR_MPS 10'h0A8
`define ECS_ADDR_AUTO 10'h0B0
`define ECS_ADDR_CTRL 10'h100
`define ECS_ADDR_STAT 10'h104
`define ECS_ADDR_IEN 10'h108

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ECS_RD_MULTI_BIT 15
`define ECS_RD_BLK_HI 13
`define ECS_RD_BLK_LO 8
`define ECS_WR_MULTI_BIT 7
`define ECS_WR_BLK_HI 5
`define ECS_WR_BLK_LO 0
`define ECS_MPS_HI 6
`define ECS_AUTO_CFG_BIT 1
`define ECS_AUTO_ADR_BIT 0
`define ECS_HS_HI 15
`define ECS_HS_LO 14
`define ECS_VALID_BIT 13
`define ECS_CLEAR_BIT 12
`define ECS_DIR_BIT 0
`define ECS_ST_STAGE_BIT 0
`define ECS_ST_OVR_BIT 1
`define ECS_ST_DEVICE_STATE_CHANGE_FLAG_BIT 2
`define ECS_ST_RANGE_BIT 3
`define ECS_IEN_OVR_BIT 0
`define ECS_IEN_STAGE_ERROR_IRQ_ENABLE_BIT 1
`define ECS_IEN_CONFIG_CHANGE_IRQ_ENABLE_BIT 2
`define ECS_IEN_ADDRESS_CHANGE_IRQ_ENABLE_BIT 3

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define ECS_RST_BUF_MODE 16'h0000
`define ECS_RST_MPS 16'h0008
`define ECS_RST_AUTO 16'h0000
`define ECS_BLOCK_BYTES 13'h0040
`define ECS_LAST_BLOCK 6'h2F
`define ECS_FIFO_BYTES 13'h0C00
`define ECS_CONT_RX_BYTES 9'h100
`define ECS_HS_NAK 2'h0
`define ECS_HS_BUF 2'h1

`endif

// ===== logic/ecs_pkg.sv
`default_nettype none
package ecs_pkg;

    // Device state, one-hot
    typedef enum logic [2:0] {
        DS_DEFAULT = 3'b001,
        DS_ADDRESS = 3'b010,
        DS_CONFIGURED = 3'b100
    } ecs_dev_state_t;

    // EP0 buffer phase, one-hot
    typedef enum logic [1:0] {
        BP_OPEN = 2'b01,
        BP_VALID = 2'b10
    } ecs_buf_phase_t;

    // Answer to a data-stage token
    typedef enum logic [1:0] {
        RS_NAK = 2'h0,
        RS_ACK = 2'h1,
        RS_DATA = 2'h2,
        RS_STALL = 2'h3
    } ecs_resp_t;

    // Decoded setup request
    typedef struct packed {
        logic set_address;
        logic set_config;
        logic value_nonzero;
    } ecs_req_t;

    // Data-stage answer from the block
    typedef struct packed {
        ecs_resp_t code;
        logic [6:0] len;
    } ecs_ans_t;

endpackage
`default_nettype wire

// ===== tb/ecs_ep0_cfg_checker.sv
`default_nettype none
module ecs_ep0_cfg_checker #(
    parameter int AW = 10
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Protocol engine
    input wire logic in_token_stb,
    input wire logic out_pkt_stb,
    input wire logic [10:0] out_pkt_len,
    input wire logic req_stb,
    input wire ecs_pkg::ecs_req_t req,
    input wire ecs_pkg::ecs_dev_state_t dev_state,
    input wire ecs_pkg::ecs_ans_t ans,
    input wire logic ans_stb,
    input wire logic auto_zlp_stb,
    input wire logic [11:0] rd_buf_base,
    input wire logic [11:0] wr_buf_base
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Properties
    // ----
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    ans_cause_a: assert property (ans_stb |-> $past(in_token_stb || out_pkt_stb))
        else $error("answer without token");
    ans_len_a: assert property (ans_stb && ans.code == ecs_pkg::RS_DATA |-> ans.len <= 7'h40)
        else $error("packet too long");
    over_size_a: assert property (out_pkt_stb && out_pkt_len > 11'h040 |=> !(ans_stb && ans.code == ecs_pkg::RS_ACK))
        else $error("oversize packet acked");
    zlp_cause_a: assert property (auto_zlp_stb |-> $past(req_stb && (req.set_address || req.set_config)))
        else $error("status without request");
    zlp_state_a: assert property (auto_zlp_stb && $past(req.set_address) |-> $past(dev_state) == ecs_pkg::DS_DEFAULT)
        else $error("address status outside default");
    blk_align_a: assert property (rd_buf_base[5:0] == 6'h00 && wr_buf_base[5:0] == 6'h00)
        else $error("base not on block");
endmodule
bind ecs_ep0_cfg ecs_ep0_cfg_checker #(.AW(AW)) i_ecs_ep0_cfg_checker (.*);
`default_nettype wire

// ===== tb/ecs_host_model.sv
`default_nettype none
module ecs_host_model (
    // Clock
    input wire logic aclk,
    // Engine strobes
    output logic in_token_stb,
    output logic out_pkt_stb,
    output logic [10:0] out_pkt_len,
    output logic req_stb,
    output ecs_pkg::ecs_req_t req,
    output ecs_pkg::ecs_dev_state_t dev_state
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {in_token_stb, out_pkt_stb, req_stb, out_pkt_len, req} = '0;
        dev_state = ecs_pkg::DS_DEFAULT;
    end
    task automatic tok();
        @(posedge aclk);
        in_token_stb <= 1'b1;
        @(posedge aclk);
        in_token_stb <= 1'b0;
    endtask
    // Length is garbled once the strobe drops
    task automatic outp(input logic [10:0] n);
        @(posedge aclk);
        out_pkt_stb <= 1'b1;
        out_pkt_len <= n;
        @(posedge aclk);
        out_pkt_stb <= 1'b0;
        out_pkt_len <= ~n;
    endtask
    task automatic setup(input ecs_pkg::ecs_req_t q, input ecs_pkg::ecs_dev_state_t s);
        @(posedge aclk);
        dev_state <= s;
        req <= q;
        req_stb <= 1'b1;
        @(posedge aclk);
        req_stb <= 1'b0;
        req <= ~q;
    endtask
endmodule
`default_nettype wire

// ===== tb/ep0_control_transfer_setup_test.sv
`include "ecs_regs.svh"
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module ep0_control_transfer_setup_test;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [9:0] a; logic [15:0] d; logic [15:0] e; logic [1:0] s;} ecs_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, buf_wr_stb, in_token_stb, out_pkt_stb;
    logic req_stb, ans_stb, auto_zlp_stb, buffer_valid_flag, stage_change_flag, empty_or_oversize_flag;
    logic device_state_change_flag;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, buf_wr_bytes, r;
    logic [10:0] out_pkt_len;
    logic [11:0] rd_buf_base, wr_buf_base, act_buf_base;
    logic [8:0] act_buf_bytes, rx_fill_bytes;
    logic [15:0] q;
    ecs_pkg::ecs_req_t req;
    ecs_pkg::ecs_dev_state_t dev_state;
    ecs_pkg::ecs_ans_t ans;
    int bad_count, checks;
    ecs_row_t rows [4] = '{'{`ECS_ADDR_BUF_MODE, 16'h8A85, 16'h8A85, 2'h0},
        '{`ECS_ADDR_MPS, 16'h0040, 16'h0040, 2'h0}, '{`ECS_ADDR_AUTO, 16'h0003, 16'h0003, 2'h0},
        '{10'h3FC, 16'h1234, 16'h0000, 2'h3}};
    logic [1:0] hs [3] = '{2'h0, 2'h2, 2'h3};
    ecs_pkg::ecs_resp_t hx [3] = '{ecs_pkg::RS_NAK, ecs_pkg::RS_STALL, ecs_pkg::RS_STALL};
    ecs_ep0_cfg i_ecs_ep0_cfg (.*, .s_axi_wstrb(4'hF), .cont_tx_len(9'h010));
    ecs_host_model i_ecs_host_model (.*);
    initial begin
        aclk = 0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic complete_run();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----
    // Bus and buffer tasks
    // ----
    task automatic wr(input logic [9:0] a, input logic [15:0] d, output logic [1:0] rs);
        logic ta, tw, tb;
        tb = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, 16'h0000, d, 3'h7};
        repeat (40) if (!tb) begin
            @(negedge aclk);
            {ta, tw, tb, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
        if (!tb) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic rd(input logic [9:0] a, output logic [15:0] d, output logic [1:0] rs);
        logic ta, tv;
        tv = 0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        repeat (40) if (!tv) begin
            @(negedge aclk);
            {ta, tv, d, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata[15:0], s_axi_rresp};
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tv) s_axi_rready <= 1'b0;
        end
        if (!tv) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic fill(input int n);
        repeat (n) begin
            @(posedge aclk);
            buf_wr_stb <= 1'b1;
            buf_wr_bytes <= 2'h2;
        end
        @(posedge aclk);
        buf_wr_stb <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic tok_chk(input ecs_pkg::ecs_resp_t c, input logic [6:0] n);
        i_ecs_host_model.tok();
        #1 `CHK("code", c, ans.code)
        `CHK("len", n, ans.len)
    endtask
    task automatic zlp(input logic [2:0] q3, input ecs_pkg::ecs_dev_state_t s, input logic e);
        i_ecs_host_model.setup(q3, s);
        #1 `CHK("zlp", e, auto_zlp_stb)
    endtask
    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, buf_wr_stb, aresetn} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, buf_wr_bytes} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, r);
            `CHK("bresp", rows[i].s, r)
            rd(rows[i].a, q, r);
            `CHK("rdata", rows[i].e, q)
            `CHK("rresp", rows[i].s, r)
        end
        `CHK("rd_base", 12'h280, rd_buf_base)
        `CHK("wr_base", 12'h140, wr_buf_base)
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ECS_ADDR_MPS, q, r);
        `CHK("mps_rst", 16'h0008, q)
        rd(`ECS_ADDR_BUF_MODE, q, r);
        `CHK("mode_rst", 16'h0000, q)
        wr(`ECS_ADDR_CTRL, 16'h4001, r);
        fill(4);
        `CHK("valid", 1'b1, buffer_valid_flag)
        `CHK("act1", 9'h040, act_buf_bytes)
        tok_chk(ecs_pkg::RS_DATA, 7'h08);
        fill(1);
        wr(`ECS_ADDR_CTRL, 16'h6001, r);
        tok_chk(ecs_pkg::RS_DATA, 7'h02);
        for (int i = 0; i < 3; i++) begin
            wr(`ECS_ADDR_CTRL, {hs[i], 14'h0001}, r);
            fill(4);
            i_ecs_host_model.tok();
            #1 `CHK("hs", hx[i], ans.code)
            wr(`ECS_ADDR_CTRL, 16'h1001, r);
        end
        wr(`ECS_ADDR_BUF_MODE, 16'h8000, r);
        wr(`ECS_ADDR_CTRL, 16'h4001, r);
        fill(8);
        `CHK("cvalid", 1'b1, buffer_valid_flag)
        `CHK("act2", 9'h010, act_buf_bytes)
        tok_chk(ecs_pkg::RS_DATA, 7'h08);
        tok_chk(ecs_pkg::RS_DATA, 7'h08);
        wr(`ECS_ADDR_CTRL, 16'h4000, r);
        i_ecs_host_model.outp(11'h041);
        #1 `CHK("over64", ecs_pkg::RS_STALL, ans.code)
        i_ecs_host_model.outp(11'h009);
        #1 `CHK("over", ecs_pkg::RS_STALL, ans.code)
        i_ecs_host_model.outp(11'h008);
        #1 `CHK("ack", ecs_pkg::RS_ACK, ans.code)
        repeat (3) @(posedge aclk);
        `CHK("ovr", 1'b1, empty_or_oversize_flag)
        `CHK("rx", 1'b1, buffer_valid_flag)
        `CHK("rxn", 9'h008, rx_fill_bytes)
        `CHK("act3", 9'h040, act_buf_bytes)
        i_ecs_host_model.tok();
        #1 `CHK("dir", 1'b0, ans_stb)
        wr(`ECS_ADDR_STAT, 16'h000F, r);
        wr(`ECS_ADDR_AUTO, 16'h0001, r);
        wr(`ECS_ADDR_IEN, 16'h0008, r);
        zlp(3'b100, ecs_pkg::DS_DEFAULT, 1'b1);
        repeat (3) @(posedge aclk);
        `CHK("stage0", 1'b0, stage_change_flag)
        `CHK("dvst0", 1'b0, device_state_change_flag)
        zlp(3'b100, ecs_pkg::DS_ADDRESS, 1'b0);
        repeat (3) @(posedge aclk);
        `CHK("stage1", 1'b1, stage_change_flag)
        `CHK("dvst1", 1'b1, device_state_change_flag)
        wr(`ECS_ADDR_AUTO, 16'h0002, r);
        zlp(3'b011, ecs_pkg::DS_ADDRESS, 1'b1);
        zlp(3'b010, ecs_pkg::DS_CONFIGURED, 1'b1);
        zlp(3'b011, ecs_pkg::DS_CONFIGURED, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
